/* File: sso_pkg.sv */
package sso_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int SPD_W  = 16;  // Speed in r/min, signed
   localparam int DRP_W  = 24;  // Droop pulse count, signed
   localparam int TRQ_W  = 16;  // Torque level, signed
   localparam int DLY_W  = 16;  // Brake delay in ms
   localparam int CNT_W  = 27;  // Power-on counter width
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 100;
   localparam int POWER_ON_MS   = 1000;
   localparam int POWER_ON_CYC  = POWER_ON_MS * 1000 * CLK_MHZ;
   localparam int MS_CYC        = 1000 * CLK_MHZ;
   // ----------------------------------------------------------------
   // Speed thresholds and reset values
   // ----------------------------------------------------------------
   localparam logic [SPD_W-1:0] SA_LOW_CMD_RPM   = 16'h0014;  // 20 r/min
   localparam logic [SPD_W-1:0] ZSP_DEF_RPM      = 16'h0032;  // 50 r/min
   localparam logic [SPD_W-1:0] ZSP_OFF_RPM      = 16'h0046;  // 70 r/min
   localparam logic [SPD_W-1:0] SA_BAND_RPM      = 16'h000A;  // Approximate match band
   localparam logic [DLY_W-1:0] BRAKE_DLY_DEF_MS = 16'h0000;
   localparam logic [7:0]       FLAGS_RST        = 8'h00;
   // ----------------------------------------------------------------
   // Output assignment mask bit positions
   // ----------------------------------------------------------------
   localparam int ASN_RDY = 0;
   localparam int ASN_DB  = 1;
   localparam int ASN_SA  = 2;
   localparam int ASN_TLC = 3;
   localparam int ASN_ZSP = 4;
   localparam int ASN_W   = 5;
   // ----------------------------------------------------------------
   // Control loop modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SSO_MODE_POS = 2'h0,
      SSO_MODE_SPD = 2'h1,
      SSO_MODE_TRQ = 2'h2
   } sso_mode_type;
   // Brake sequencer states, one-hot
   typedef enum logic [2:0] {
      SSO_BRK_HOLD  = 3'b001,
      SSO_BRK_DELAY = 3'b010,
      SSO_BRK_REL   = 3'b100
   } sso_brk_type;
   // Magnitude of a signed speed
   function automatic logic [SPD_W-1:0] sso_abs(input logic signed [SPD_W-1:0] v);
      return v[SPD_W-1] ? SPD_W'(-v) : v;
   endfunction
endpackage

/* File: sso_speed_if.sv */
`timescale 1ns/1ps
interface sso_speed_if;
   import sso_pkg::*;
   logic [SPD_W-1:0] spd_mag;
   logic [SPD_W-1:0] cmd_mag;
   logic [SPD_W-1:0] zsp_thr;
   logic             servo_on;
   logic             zero_speed_flag;
   logic             sa;
   modport top (output spd_mag, output cmd_mag, output zsp_thr, output servo_on,
                input zero_speed_flag, input sa);
   modport cmp (input spd_mag, input cmd_mag, input zsp_thr, input servo_on,
                output zero_speed_flag, output sa);
endinterface

/* File: sso_speed_cmp.sv */
`timescale 1ns/1ps
module sso_speed_cmp (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   sso_speed_if.cmp  spd
);
   import sso_pkg::*;
   logic zsp_reg;
   logic sa_reg;
   wire  logic zsp_next;
   wire  logic sa_next;
   wire  logic [SPD_W-1:0] diff;
   wire  logic [SPD_W-1:0] thr_off;
   // ----------------------------------------------------------------
   // Comparisons
   // ----------------------------------------------------------------
   // Off level keeps the same offset above a changed on level
   assign thr_off  = (spd.zsp_thr == ZSP_DEF_RPM) ? ZSP_OFF_RPM
                   : SPD_W'(spd.zsp_thr + (ZSP_OFF_RPM - ZSP_DEF_RPM));
   assign zsp_next = zsp_reg ? (spd.spd_mag < thr_off)     // [R16]
                             : (spd.spd_mag <= spd.zsp_thr); // [R15]
   assign diff     = (spd.spd_mag > spd.cmd_mag) ? SPD_W'(spd.spd_mag - spd.cmd_mag)
                                                 : SPD_W'(spd.cmd_mag - spd.spd_mag);
   assign sa_next  = spd.servo_on &&                          // [R9]
                     ((spd.cmd_mag <= SA_LOW_CMD_RPM) ||      // [R11]
                      (diff <= SA_BAND_RPM));                 // [R10]
   // Flag registers
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         zsp_reg <= 1'b0;
         sa_reg  <= 1'b0;
      end else begin
         zsp_reg <= zsp_next;
         sa_reg  <= sa_next;
      end
   end
   assign spd.zero_speed_flag = zsp_reg;
   assign spd.sa  = sa_reg;

   AST_SA_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !spd.servo_on |=> !sa_reg) else $error("speed flag set while servo off"); // [R9]
   AST_SA_LOW: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (spd.servo_on && spd.cmd_mag <= SA_LOW_CMD_RPM) |=> sa_reg)
      else $error("speed flag low at low command"); // [R11]
   AST_ZSP_HYST: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (zsp_reg && spd.zsp_thr == ZSP_DEF_RPM && spd.spd_mag == 16'h003C) |=> zsp_reg)
      else $error("zero speed dropped inside band"); // [R16]
   AST_ZSP_ON: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (spd.spd_mag <= spd.zsp_thr) |=> zsp_reg) else $error("zero speed not set"); // [R15]
endmodule

/* File: sso_top.sv */
`timescale 1ns/1ps
// Functional notes
// R1 - Fault-free output drops at power loss or base drive shutoff.
// R2 - Fault-free output rises about one second after power-on without alarm.
// R3 - Brake release drops on servo off or alarm; release waits configured delay.
// R4 - In-position set while droop count lies inside configured range.
// R5 - In-position set when servo-on becomes active.
// R6 - In-position not valid in speed loop mode.
// R7 - Ready set only when servo on and amplifier ready.
// R8 - Dynamic brake interlock drops as dynamic brake engages.
// R9 - Speed-reached low while servo off.
// R10 - Speed-reached set when speed approximately equals command.
// R11 - Command at or below 20 r/min keeps speed-reached set.
// R12 - Speed-reached not valid in position loop mode.
// R13 - Torque-limiting set when torque reaches controller limit.
// R14 - Torque-limiting low while servo off.
// R15 - Zero-speed set at or below threshold, default 50 r/min.
// R16 - Zero-speed clears only at 70 r/min, giving hysteresis; code clears at threshold + 20 r/min for a threshold other than 50.
// R17 - Optional outputs drive only after assignment to output pins.
// R18 - All flags registered; reset deasserts every flag.
module sso_top #(
   parameter int POWER_ON_CYCLES = sso_pkg::POWER_ON_CYC,
   parameter int MS_CYCLES       = sso_pkg::MS_CYC
) (
   input  wire logic                            clk_in,
   input  wire logic                            arst_n_in,
   input  wire logic                            servo_on_in,
   input  wire logic                            alarm_in,
   input  wire logic                            base_off_in,
   input  wire logic                            amp_ready_in,
   input  wire logic                            dyn_brake_on_in,
   input  wire sso_pkg::sso_mode_type           mode_in,
   input  wire logic signed [sso_pkg::DRP_W-1:0] droop_in,
   input  wire logic [sso_pkg::DRP_W-1:0]       inpos_range_in,
   input  wire logic signed [sso_pkg::SPD_W-1:0] speed_in,
   input  wire logic signed [sso_pkg::SPD_W-1:0] speed_cmd_in,
   input  wire logic [sso_pkg::SPD_W-1:0]       zsp_thr_in,
   input  wire logic signed [sso_pkg::TRQ_W-1:0] torque_in,
   input  wire logic [sso_pkg::TRQ_W-1:0]       torque_lim_in,
   input  wire logic [sso_pkg::DLY_W-1:0]       brake_dly_ms_in,
   input  wire logic [sso_pkg::ASN_W-1:0]       assign_in,
   output logic                                 fault_free_output_out,
   output logic                                 brake_release_interlock_out,
   output logic                                 in_position_flag_out,
   output logic                                 ready_out,
   output logic                                 dyn_brake_interlock_out,
   output logic                                 speed_reached_flag_out,
   output logic                                 torque_limit_active_out,
   output logic                                 zero_speed_flag_out
);
   import sso_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [CNT_W-1:0]  pwr_cnt_reg;
   logic              pwr_done_reg;
   logic              servo_on_d_reg;
   logic [16:0]       ms_cnt_reg;
   logic              ms_tick_reg;
   logic [DLY_W-1:0]  brk_cnt_reg;
   sso_brk_type       brk_state_reg;
   sso_brk_type       brk_state_next;
   logic              alm_reg;
   logic              mbr_reg;
   logic              inp_reg;
   logic              rdy_reg;
   logic              db_reg;
   logic              sa_reg;
   logic              tlc_reg;
   logic              zsp_reg;
   wire  logic [DRP_W-1:0] droop_mag;
   wire  logic [TRQ_W-1:0] torque_mag;
   wire  logic        servo_rise;
   wire  logic        brk_block;
   wire  logic        alm_next;
   wire  logic        inp_next;
   wire  logic        rdy_next;
   wire  logic        db_next;
   wire  logic        sa_next;
   wire  logic        tlc_next;
   wire  logic        zsp_next;

   sso_speed_if spd ();

   // ----------------------------------------------------------------
   // Speed comparator
   // ----------------------------------------------------------------
   assign spd.spd_mag  = sso_abs(speed_in);
   assign spd.cmd_mag  = sso_abs(speed_cmd_in);
   assign spd.zsp_thr  = zsp_thr_in;
   assign spd.servo_on = servo_on_in;

   sso_speed_cmp u_cmp (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .spd       (spd.cmp)
   );

   // ----------------------------------------------------------------
   // Power-on timer and millisecond tick
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwr_cnt_reg  <= '0;
         pwr_done_reg <= 1'b0;
      end else if (!pwr_done_reg) begin
         pwr_cnt_reg  <= pwr_cnt_reg + 1'b1;
         pwr_done_reg <= (pwr_cnt_reg == CNT_W'(POWER_ON_CYCLES - 1)); // [R2]
      end
   end

   // Slow enable for brake delay
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ms_cnt_reg  <= '0;
         ms_tick_reg <= 1'b0;
      end else begin
         ms_tick_reg <= (ms_cnt_reg == 17'(MS_CYCLES - 1));
         ms_cnt_reg  <= (ms_cnt_reg == 17'(MS_CYCLES - 1)) ? '0 : ms_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Brake release sequencer
   // ----------------------------------------------------------------
   assign brk_block = !servo_on_in || alarm_in || base_off_in; // [R3]

   always_comb begin
      brk_state_next = brk_state_reg;
      case (brk_state_reg)
         SSO_BRK_HOLD: begin
            if (!brk_block) begin
               brk_state_next = (brake_dly_ms_in == '0) ? SSO_BRK_REL : SSO_BRK_DELAY;
            end
         end
         SSO_BRK_DELAY: begin
            if (brk_block) begin
               brk_state_next = SSO_BRK_HOLD;
            end else if (ms_tick_reg && brk_cnt_reg + 1'b1 >= brake_dly_ms_in) begin
               brk_state_next = SSO_BRK_REL; // [R3]
            end
         end
         SSO_BRK_REL: begin
            if (brk_block) begin
               brk_state_next = SSO_BRK_HOLD;
            end
         end
         default: brk_state_next = SSO_BRK_HOLD;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         brk_state_reg <= SSO_BRK_HOLD;
         brk_cnt_reg   <= BRAKE_DLY_DEF_MS;
      end else begin
         brk_state_reg <= brk_state_next;
         if (brk_state_reg != SSO_BRK_DELAY) begin
            brk_cnt_reg <= '0;
         end else if (ms_tick_reg) begin
            brk_cnt_reg <= brk_cnt_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flag decode
   // ----------------------------------------------------------------
   assign droop_mag  = droop_in[DRP_W-1] ? DRP_W'(-droop_in) : droop_in;
   assign torque_mag = torque_in[TRQ_W-1] ? TRQ_W'(-torque_in) : torque_in;
   assign servo_rise = servo_on_in && !servo_on_d_reg;

   assign alm_next = pwr_done_reg && !alarm_in && !base_off_in;          // [R1] [R2]
   assign inp_next = (mode_in != SSO_MODE_SPD) &&                         // [R6]
                     (servo_rise ||                                       // [R5]
                      (servo_on_in && droop_mag <= inpos_range_in));      // [R4]
   assign rdy_next = assign_in[ASN_RDY] && servo_on_in && amp_ready_in   // [R7] [R17]
                     && !alarm_in;
   assign db_next  = assign_in[ASN_DB] && !dyn_brake_on_in;              // [R8] [R17]
   assign sa_next  = assign_in[ASN_SA] && (mode_in != SSO_MODE_POS)      // [R12] [R17]
                     && spd.sa;                                           // [R10]
   assign tlc_next = assign_in[ASN_TLC] && servo_on_in &&                // [R14] [R17]
                     (torque_mag >= torque_lim_in);                       // [R13]
   assign zsp_next = assign_in[ASN_ZSP] && spd.zero_speed_flag;                      // [R17]

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         {alm_reg, mbr_reg, inp_reg, rdy_reg,
          db_reg, sa_reg, tlc_reg, zsp_reg} <= FLAGS_RST; // [R18]
         servo_on_d_reg <= 1'b0;
      end else begin
         alm_reg        <= alm_next;
         mbr_reg        <= (brk_state_next == SSO_BRK_REL);
         inp_reg        <= inp_next;
         rdy_reg        <= rdy_next;
         db_reg         <= db_next;
         sa_reg         <= sa_next;
         tlc_reg        <= tlc_next;
         zsp_reg        <= zsp_next;
         servo_on_d_reg <= servo_on_in;
      end
   end

   assign fault_free_output_out       = alm_reg;
   assign brake_release_interlock_out = mbr_reg;
   assign in_position_flag_out        = inp_reg;
   assign ready_out                   = rdy_reg;
   assign dyn_brake_interlock_out     = db_reg;
   assign speed_reached_flag_out      = sa_reg;
   assign torque_limit_active_out     = tlc_reg;
   assign zero_speed_flag_out         = zsp_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_fault_seen;
      alarm_in || base_off_in;
   endsequence

   AST_ALM_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      s_fault_seen |=> !alm_reg) else $error("fault-free output held in fault"); // [R1]
   AST_ALM_WAIT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !pwr_done_reg |=> !alm_reg) else $error("fault-free output before power-on"); // [R2]
   AST_MBR_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      brk_block |=> !mbr_reg) else $error("brake released while blocked"); // [R3]
   AST_INP_RISE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (servo_rise && mode_in != SSO_MODE_SPD) |=> inp_reg)
      else $error("in-position missing at servo on"); // [R5]
   AST_INP_SPD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (mode_in == SSO_MODE_SPD) |=> !inp_reg) else $error("in-position in speed mode"); // [R6]
   AST_RDY: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rdy_reg |-> $past(servo_on_in) && $past(amp_ready_in))
      else $error("ready without servo on"); // [R7]
   AST_DB: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      dyn_brake_on_in |=> !db_reg) else $error("interlock held with brake on"); // [R8]
   AST_SA_POS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (mode_in == SSO_MODE_POS) |=> !sa_reg) else $error("speed flag in position mode"); // [R12]
   AST_TLC: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (assign_in[ASN_TLC] && servo_on_in && torque_mag >= torque_lim_in) |=> tlc_reg)
      else $error("torque limit flag missing"); // [R13]
   AST_TLC_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !servo_on_in |=> !tlc_reg) else $error("torque flag with servo off"); // [R14]
   AST_ASSIGN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !assign_in[ASN_ZSP] |=> !zero_speed_flag_out) else $error("unassigned output driven"); // [R17]
endmodule

/* File: sso_ctrl_model.sv */
`timescale 1ns/1ps
module sso_ctrl_model (
   input  wire logic                      clk_in,
   input  wire logic                      arst_n_in,
   input  wire logic [sso_pkg::ASN_W-1:0] assign_in,
   input  wire logic [7:0]                flags_in,
   output logic      [7:0]                status_out,
   output logic                           event_out
);
   import sso_pkg::*;
   // Optional flags are trusted only once mapped to a pin
   wire logic [7:0] opt_mask = {3'b111, assign_in[ASN_RDY], assign_in[ASN_DB],
                                assign_in[ASN_SA], assign_in[ASN_TLC], assign_in[ASN_ZSP]};
   wire logic [7:0] seen     = flags_in & opt_mask;
   // Latch the seen status and note every change
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_out <= 8'h00;
         event_out  <= 1'b0;
      end else begin
         status_out <= seen;
         event_out  <= (seen != status_out);
      end
   end
endmodule

/* File: servo_status_outputs_bench.sv */
`timescale 1ns/1ps
module servo_status_outputs_bench;
   import sso_pkg::*;
   localparam logic [7:0] F_FF = 8'h80, F_BRK = 8'h40, F_INP = 8'h20, F_RDY = 8'h10;
   localparam logic [7:0] F_DB = 8'h08, F_SA = 8'h04, F_TLC = 8'h02, F_ZSP = 8'h01;
   localparam logic [7:0] F_OPT = 8'h1f;
   typedef struct packed {logic [7:0] mask; logic [7:0] val;} sso_note_type;
   logic                    clk_in, arst_n_in, servo_on, alarm, base_off, amp_ready, dyn_brake;
   sso_mode_type            mode;
   logic signed [DRP_W-1:0] droop;
   logic [DRP_W-1:0]        inp_rng;
   logic signed [SPD_W-1:0] speed, cmd;
   logic [SPD_W-1:0]        zthr;
   logic signed [TRQ_W-1:0] trq;
   logic [TRQ_W-1:0]        tlim;
   logic [DLY_W-1:0]        bdly;
   logic [ASN_W-1:0]        asn;
   logic [7:0]              flags;
   logic [7:0]              ctrl_status;
   int                      error_cnt = 0;
   int                      compares = 0;
   int                      seed = 32'h1000_02dd;
   sso_note_type            exp_q [$];
   event                    chk_ev;
   int sa_tab [6][2] = '{'{20, 500}, '{-20, -500}, '{21, 500}, '{300, 310}, '{300, 311},
                         '{-300, 290}};
   int tq_tab [4][2] = '{'{199, 0}, '{200, 1}, '{-200, 1}, '{-150, 0}};
   int zs_tab [8][2] = '{'{100, 0}, '{50, 1}, '{69, 1}, '{70, 0}, '{-50, 1}, '{-69, 1},
                         '{-70, 0}, '{0, 1}};

   // Design under test with shortened counts
   sso_top #(.POWER_ON_CYCLES(50), .MS_CYCLES(10)) sso_top_i (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .servo_on_in(servo_on), .alarm_in(alarm),
      .base_off_in(base_off), .amp_ready_in(amp_ready), .dyn_brake_on_in(dyn_brake),
      .mode_in(mode), .droop_in(droop), .inpos_range_in(inp_rng), .speed_in(speed),
      .speed_cmd_in(cmd), .zsp_thr_in(zthr), .torque_in(trq), .torque_lim_in(tlim),
      .brake_dly_ms_in(bdly), .assign_in(asn),
      .fault_free_output_out(flags[7]), .brake_release_interlock_out(flags[6]),
      .in_position_flag_out(flags[5]), .ready_out(flags[4]),
      .dyn_brake_interlock_out(flags[3]), .speed_reached_flag_out(flags[2]),
      .torque_limit_active_out(flags[1]), .zero_speed_flag_out(flags[0]));
   // Controller side of the discrete outputs
   sso_ctrl_model sso_ctrl_model_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .assign_in(asn),
      .flags_in(flags), .status_out(ctrl_status), .event_out());

   // 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic expect_flags(input logic [7:0] m, input logic [7:0] v);
      exp_q.push_back('{m, v});
      -> chk_ev;
   endtask
   task automatic cmp_flags(input logic [7:0] m, input logic [7:0] v, input logic [7:0] got);
      compares++;
      if ((got & m) !== (v & m)) begin
         error_cnt++;
         $display("Error at %0t: expected %h got %h", $time, v & m, got & m);
      end
   endtask
   task automatic results;
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Speed reached expectation from command and speed
   function automatic logic [7:0] sa_exp(input int c, input int s);
      int ac;
      int as;
      ac = (c < 0) ? -c : c;
      as = (s < 0) ? -s : s;
      return (ac <= 20 || (as - ac <= 10 && ac - as <= 10)) ? F_SA : 8'h00;
   endfunction

   // Monitor: every queued note, oldest first, against settled outputs
   initial begin
      sso_note_type n;
      forever begin
         @(chk_ev);
         while (exp_q.size() > 0) begin
            n = exp_q.pop_front();
            cmp_flags(n.mask, n.val, flags);
         end
      end
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      results();
   end

   // Main sequence, inputs change at falling edges
   initial begin
      int c;
      int s;
      {arst_n_in, servo_on, alarm, base_off, amp_ready, dyn_brake} = 6'b00_0010;
      mode = SSO_MODE_POS;
      droop = 24'sh00_03e8;
      inp_rng = 24'h00_000a;
      speed = 16'sh01f4;
      cmd = 16'sh01f4;
      zthr = 16'h0032;
      trq = 16'sh0000;
      tlim = 16'h00c8;
      bdly = 16'h0000;
      asn = 5'h1f;
      step(12);
      expect_flags(8'hff, 8'h00);
      arst_n_in = 1'b1;
      step(50);
      expect_flags(F_FF, 8'h00);
      step(4);
      expect_flags(F_FF, F_FF);
      servo_on = 1'b1;
      step(1);
      expect_flags(F_INP, F_INP);
      step(3);
      expect_flags(F_INP | F_BRK | F_RDY | F_DB | F_SA, F_BRK | F_RDY | F_DB);
      droop = -24'sh00_0005;
      step(3);
      expect_flags(F_INP, F_INP);
      droop = -24'sh00_000b;
      step(3);
      expect_flags(F_INP, 8'h00);
      mode = SSO_MODE_SPD;
      droop = 24'sh00_0000;
      step(3);
      expect_flags(F_INP | F_SA, F_SA);
      alarm = 1'b1;
      step(1);
      expect_flags(F_FF | F_BRK | F_RDY, 8'h00);
      alarm = 1'b0;
      base_off = 1'b1;
      step(1);
      expect_flags(F_FF | F_BRK, 8'h00);
      base_off = 1'b0;
      servo_on = 1'b0;
      bdly = 16'h0003;
      step(3);
      expect_flags(F_RDY | F_SA | F_BRK | F_FF, F_FF);
      servo_on = 1'b1;
      step(25);
      expect_flags(F_BRK, 8'h00);
      step(10);
      expect_flags(F_BRK, F_BRK);
      foreach (sa_tab[i]) begin
         cmd = SPD_W'(sa_tab[i][0]);
         speed = SPD_W'(sa_tab[i][1]);
         step(3);
         expect_flags(F_SA, sa_exp(sa_tab[i][0], sa_tab[i][1]));
      end
      mode = SSO_MODE_TRQ;
      repeat (20) begin
         c = $random(seed) % 400;
         s = c + $random(seed) % 16;
         cmd = SPD_W'(c);
         speed = SPD_W'(s);
         step(3);
         expect_flags(F_SA, sa_exp(c, s));
      end
      foreach (tq_tab[i]) begin
         trq = TRQ_W'(tq_tab[i][0]);
         step(2);
         expect_flags(F_TLC, tq_tab[i][1] ? F_TLC : 8'h00);
      end
      trq = 16'sh012c;
      servo_on = 1'b0;
      step(2);
      expect_flags(F_TLC, 8'h00);
      servo_on = 1'b1;
      foreach (zs_tab[i]) begin
         speed = SPD_W'(zs_tab[i][0]);
         step(3);
         expect_flags(F_ZSP, zs_tab[i][1] ? F_ZSP : 8'h00);
      end
      dyn_brake = 1'b1;
      step(2);
      expect_flags(F_DB, 8'h00);
      dyn_brake = 1'b0;
      cmd = 16'sh0000;
      asn = 5'h00;
      step(3);
      expect_flags(F_OPT, 8'h00);
      cmp_flags(F_OPT, 8'h00, ctrl_status);
      asn = 5'h1f;
      step(3);
      expect_flags(F_OPT, F_OPT);
      cmp_flags(F_OPT, F_OPT, ctrl_status);
      amp_ready = 1'b0;
      step(2);
      expect_flags(F_RDY, 8'h00);
      arst_n_in = 1'b0;
      step(1);
      expect_flags(8'hff, 8'h00);
      step(1);
      results();
   end
endmodule
